// *** rtl/lcr_pkg.sv ***
// Shared constants for the cursor, scroll, glyph-base and depth register bank.
package lcr_pkg;
  localparam logic [15:0] OFF_GLYPH_LO    = 16'h8019;
  localparam logic [15:0] OFF_GLYPH_HI    = 16'h801A;
  localparam logic [15:0] OFF_SCROLL      = 16'h801B;
  localparam logic [15:0] OFF_CURSOR_LO   = 16'h801C;
  localparam logic [15:0] OFF_CURSOR_HI   = 16'h801D;
  localparam logic [15:0] OFF_CURRD_LO    = 16'h801E;
  localparam logic [15:0] OFF_CURRD_HI    = 16'h801F;
  localparam logic [15:0] OFF_DEPTH       = 16'h8020;
  localparam logic [7:0]  CMD_DIR_RIGHT   = 8'h4C;
  localparam logic [7:0]  CMD_DIR_LEFT    = 8'h4D;
  localparam logic [7:0]  CMD_DIR_UP      = 8'h4E;
  localparam logic [7:0]  CMD_DIR_DOWN    = 8'h4F;
  localparam logic [7:0]  CMD_MEM_WRITE   = 8'h42;
  localparam logic [7:0]  CMD_MEM_READ    = 8'h43;
  localparam logic [7:0]  CMD_CURSOR_WR   = 8'h46;
  localparam logic [7:0]  CMD_CURSOR_RD   = 8'h47;
  localparam logic [7:0]  CMD_SCROLL      = 8'h5A;
  localparam logic [7:0]  CMD_GLYPH_BASE  = 8'h5C;
  localparam logic [7:0]  CMD_DEPTH       = 8'h60;
  localparam logic [15:0] RST_WORD        = 16'h0000;
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  localparam logic [1:0]  DEPTH_1BPP      = 2'h0;
  localparam logic [1:0]  DEPTH_2BPP      = 2'h1;
  localparam logic [1:0]  DEPTH_4BPP      = 2'h2;
  localparam logic [1:0]  DIR_RIGHT       = 2'h0;
  localparam logic [1:0]  DIR_LEFT        = 2'h1;
  localparam logic [1:0]  DIR_UP          = 2'h2;
  localparam logic [1:0]  DIR_DOWN        = 2'h3;
  typedef enum logic [1:0] {ST_IDLE, ST_PARAM1, ST_PARAM2} lcr_state_t;
  typedef enum logic [2:0] {OP_NONE, OP_GLYPH, OP_SCROLL, OP_CURSOR, OP_DEPTH,
                            OP_READBACK, OP_MEMORY} lcr_op_t;
endpackage

// *** rtl/lcr_cursor_step.sv ***
// Next cursor address after one memory access, by shift direction.
`timescale 1ns/1ns
module lcr_cursor_step (
  input  wire logic [15:0] cursorAddr,
  input  wire logic [1:0]  direction,
  input  wire logic [15:0] rowPitch,
  output logic      [15:0] steppedAddr
);
  // Address arithmetic wraps at 64K, matching the 16-bit cursor width.
  // direction dependent step
  always_comb begin
    case (direction)
      lcr_pkg::DIR_RIGHT: steppedAddr = 16'(cursorAddr + 16'h0001);
      lcr_pkg::DIR_LEFT:  steppedAddr = 16'(cursorAddr - 16'h0001);
      lcr_pkg::DIR_UP:    steppedAddr = 16'(cursorAddr - rowPitch);
      lcr_pkg::DIR_DOWN:  steppedAddr = 16'(cursorAddr + rowPitch);
      default:            steppedAddr = cursorAddr;
    endcase
  end
endmodule // lcr_cursor_step

// *** rtl/lcr_glyph_addr.sv ***
// Glyph start address from character code, character height and glyph base.
`timescale 1ns/1ns
module lcr_glyph_addr (
  input  wire logic [7:0]  charCode,
  input  wire logic [4:0]  charHeight,
  input  wire logic [15:0] glyphBase,
  output logic      [15:0] glyphAddr
);
  logic [12:0] product;
  assign product   = 13'(charCode * charHeight);
  assign glyphAddr = 16'(glyphBase + {3'h0, product});
endmodule // lcr_glyph_addr

// *** rtl/lcr_regs.sv ***
// Register bank for glyph base, pixel scroll, cursor address and pixel depth.
`timescale 1ns/1ns
module lcr_regs (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        indirectMode,
  input  wire logic        directSel,
  input  wire logic        directWrite,
  input  wire logic [15:0] directAddr,
  input  wire logic [7:0]  directWdata,
  input  wire logic        cmdWrite,
  input  wire logic        paramWrite,
  input  wire logic        paramRead,
  input  wire logic [7:0]  hostData,
  input  wire logic        memAccessDone,
  input  wire logic [15:0] rowPitch,
  input  wire logic [7:0]  charCode,
  input  wire logic [4:0]  charHeight,
  output logic      [7:0]  readData,
  output logic             readValid,
  output logic             memReadReq,
  output logic             memWriteReq,
  output logic      [7:0]  memWriteData,
  output logic      [15:0] memAddr,
  output logic             directMemAllowed,
  output logic      [15:0] glyphAddr,
  output logic      [2:0]  pixelScroll,
  output logic      [1:0]  depthSelect,
  output logic      [2:0]  bitsPerPixel
);
  ////////////////////////////////////////////////////////////////////////////
  // Stored registers and command decoder state.
  // Everything here runs on mclk. The host strobes arrive already in this
  // domain, so no input passes a synchroniser.
  logic [7:0]          glyphLo_reg;
  logic [7:0]          glyphHi_reg;
  logic [2:0]          scroll_reg;
  logic [15:0]         cursor_reg;
  logic [15:0]         cursor_next;
  logic [1:0]          depth_reg;
  logic [1:0]          dir_reg;
  logic [7:0]          readData_reg;
  logic                readValid_reg;
  logic                memRead_reg;
  logic                memWrite_reg;
  logic [7:0]          memWdata_reg;
  lcr_pkg::lcr_state_t state_reg;
  lcr_pkg::lcr_op_t    op_reg;
  logic [15:0]         stepped;
  logic                directWr;
  logic                paramByte1;
  logic                paramByte2;
  logic                wrGlyphLo;
  logic                wrGlyphHi;
  logic                wrScroll;
  logic                wrCursorLo;
  logic                wrCursorHi;
  logic                wrDepth;
  logic                isDirCmd;

  // Direct register writes are honoured only outside indirect mode.
  assign directWr = directSel && directWrite && !indirectMode;
  assign paramByte1 = paramWrite && state_reg == lcr_pkg::ST_PARAM1;
  assign paramByte2 = paramWrite && state_reg == lcr_pkg::ST_PARAM2;

  // Shared offset match; every stored byte needs the same write qualifier.
  function automatic logic hitOffset(input logic        wrEn,
                                     input logic [15:0] addr,
                                     input logic [15:0] offset);
    return wrEn && addr == offset;
  endfunction

  // One decoded strobe per writable byte. Offsets 801E and 801F get no strobe,
  // which is what keeps the cursor readback bytes read-only.
  assign wrGlyphLo  = hitOffset(directWr, directAddr, lcr_pkg::OFF_GLYPH_LO);
  assign wrGlyphHi  = hitOffset(directWr, directAddr, lcr_pkg::OFF_GLYPH_HI);
  assign wrScroll   = hitOffset(directWr, directAddr, lcr_pkg::OFF_SCROLL);
  assign wrCursorLo = hitOffset(directWr, directAddr, lcr_pkg::OFF_CURSOR_LO);
  assign wrCursorHi = hitOffset(directWr, directAddr, lcr_pkg::OFF_CURSOR_HI);
  assign wrDepth    = hitOffset(directWr, directAddr, lcr_pkg::OFF_DEPTH);
  // Direction codes share their upper six bits and carry no parameter byte.
  assign isDirCmd   = cmdWrite && indirectMode &&
                      hostData[7:2] == lcr_pkg::CMD_DIR_RIGHT[7:2];

  // The stepper is purely combinational; the cursor register alone holds state.
  lcr_cursor_step u_step (
    .cursorAddr  (cursor_reg),
    .direction   (dir_reg),
    .rowPitch    (rowPitch),
    .steppedAddr (stepped)
  );

  // Glyph lookups see the base as soon as its byte lands, with no extra stage.
  lcr_glyph_addr u_glyph (
    .charCode   (charCode),
    .charHeight (charHeight),
    .glyphBase  ({glyphHi_reg, glyphLo_reg}),
    .glyphAddr  (glyphAddr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command decoder: tracks which command owns the following parameters.
  // A new command byte always restarts the decoder, so a host that abandons a
  // command halfway keeps the bytes that already landed and loses the rest.
  // Nothing waits for a missing byte, which trades completeness for never
  // leaving the bank stuck in a parameter state.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= lcr_pkg::ST_IDLE;
      op_reg    <= lcr_pkg::OP_NONE;
    end else if (cmdWrite && indirectMode) begin
      state_reg <= lcr_pkg::ST_PARAM1;
      case (hostData)
        lcr_pkg::CMD_GLYPH_BASE: op_reg <= lcr_pkg::OP_GLYPH;
        lcr_pkg::CMD_SCROLL:     op_reg <= lcr_pkg::OP_SCROLL;
        lcr_pkg::CMD_CURSOR_WR:  op_reg <= lcr_pkg::OP_CURSOR;
        lcr_pkg::CMD_DEPTH:      op_reg <= lcr_pkg::OP_DEPTH;
        lcr_pkg::CMD_CURSOR_RD:  op_reg <= lcr_pkg::OP_READBACK;
        lcr_pkg::CMD_MEM_READ:   op_reg <= lcr_pkg::OP_MEMORY;
        lcr_pkg::CMD_MEM_WRITE:  op_reg <= lcr_pkg::OP_MEMORY;
        default: begin
          op_reg    <= lcr_pkg::OP_NONE;
          state_reg <= lcr_pkg::ST_IDLE;
        end
      endcase
    end else if ((paramWrite || paramRead) && state_reg == lcr_pkg::ST_PARAM1) begin
      // Single-byte commands finish here; two-byte ones wait for the second.
      case (op_reg)
        lcr_pkg::OP_GLYPH, lcr_pkg::OP_CURSOR, lcr_pkg::OP_READBACK:
          state_reg <= lcr_pkg::ST_PARAM2;
        lcr_pkg::OP_MEMORY: state_reg <= lcr_pkg::ST_PARAM1;
        default: state_reg <= lcr_pkg::ST_IDLE;
      endcase
    end else if ((paramWrite || paramRead) && state_reg == lcr_pkg::ST_PARAM2) begin
      state_reg <= lcr_pkg::ST_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Glyph base bytes.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      glyphLo_reg <= lcr_pkg::RST_BYTE;
      glyphHi_reg <= lcr_pkg::RST_BYTE;
    end else begin
      if (wrGlyphLo) begin
        glyphLo_reg <= directWdata;
      end
      if (wrGlyphHi) begin
        glyphHi_reg <= directWdata;
      end
      if (paramByte1 && op_reg == lcr_pkg::OP_GLYPH) begin
        glyphLo_reg <= hostData;
      end
      if (paramByte2 && op_reg == lcr_pkg::OP_GLYPH) begin
        glyphHi_reg <= hostData;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel scroll and depth; the scroll is a single global value, not per layer.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scroll_reg <= lcr_pkg::RST_BYTE[2:0];
      depth_reg  <= lcr_pkg::DEPTH_1BPP;
      dir_reg    <= lcr_pkg::DIR_RIGHT;
    end else begin
      if (wrScroll) begin
        scroll_reg <= directWdata[2:0];
      end
      if (paramByte1 && op_reg == lcr_pkg::OP_SCROLL) begin
        scroll_reg <= hostData[2:0];
      end
      if (wrDepth) begin
        depth_reg <= directWdata[1:0];
      end
      if (paramByte1 && op_reg == lcr_pkg::OP_DEPTH) begin
        depth_reg <= hostData[1:0];
      end
      // Direction commands carry no parameter; the code itself selects it.
      if (isDirCmd) begin
        dir_reg <= hostData[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cursor address: loaded by the cursor-write path or stepped by access.
  always_comb begin
    cursor_next = cursor_reg;
    // Later assignments win: a load in the same cycle as a finished access
    // takes priority, so the host's new address is never stepped past.
    // only load or step
    if (memAccessDone && indirectMode) begin
      cursor_next = stepped;
    end
    if (wrCursorLo) begin
      cursor_next = {cursor_reg[15:8], directWdata};
    end
    if (wrCursorHi) begin
      cursor_next = {directWdata, cursor_reg[7:0]};
    end
    if (paramByte1 && op_reg == lcr_pkg::OP_CURSOR) begin
      cursor_next = {cursor_reg[15:8], hostData};
    end
    if (paramByte2 && op_reg == lcr_pkg::OP_CURSOR) begin
      cursor_next = {hostData, cursor_reg[7:0]};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cursor_reg <= lcr_pkg::RST_WORD;
    end else begin
      cursor_reg <= cursor_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory requests in indirect mode, addressed by the cursor.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      memRead_reg  <= 1'b0;
      memWrite_reg <= 1'b0;
      memWdata_reg <= lcr_pkg::RST_BYTE;
    end else begin
      // The decoder stays in its first parameter state after a memory command,
      // so every data byte of a stream raises one request until the next
      // command byte arrives.
      // memory commands use cursor
      memWrite_reg <= paramWrite && indirectMode && op_reg == lcr_pkg::OP_MEMORY
                      && state_reg == lcr_pkg::ST_PARAM1;
      memRead_reg  <= paramRead && indirectMode && op_reg == lcr_pkg::OP_MEMORY
                      && state_reg == lcr_pkg::ST_PARAM1;
      if (paramWrite) begin
        memWdata_reg <= hostData;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data: direct register reads and cursor readback bytes.
  // A read outside any command, or a third readback byte, answers nothing:
  // readValid stays low and the host must ignore readData then.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      readData_reg  <= lcr_pkg::RST_BYTE;
      readValid_reg <= 1'b0;
    end else begin
      readValid_reg <= 1'b0;
      if (paramRead && indirectMode && op_reg == lcr_pkg::OP_READBACK) begin
        readValid_reg <= state_reg != lcr_pkg::ST_IDLE;
        readData_reg  <= (state_reg == lcr_pkg::ST_PARAM2) ? cursor_reg[15:8]
                                                           : cursor_reg[7:0];
      end else if (directSel && !directWrite && !indirectMode) begin
        readValid_reg <= 1'b1;
        case (directAddr)
          lcr_pkg::OFF_GLYPH_LO:  readData_reg <= glyphLo_reg;
          lcr_pkg::OFF_GLYPH_HI:  readData_reg <= glyphHi_reg;
          lcr_pkg::OFF_SCROLL:    readData_reg <= {5'h00, scroll_reg};
          lcr_pkg::OFF_CURSOR_LO: readData_reg <= cursor_reg[7:0];
          lcr_pkg::OFF_CURSOR_HI: readData_reg <= cursor_reg[15:8];
          lcr_pkg::OFF_CURRD_LO:  readData_reg <= cursor_reg[7:0];
          lcr_pkg::OFF_CURRD_HI:  readData_reg <= cursor_reg[15:8];
          lcr_pkg::OFF_DEPTH:     readData_reg <= {6'h00, depth_reg};
          default:                readData_reg <= lcr_pkg::RST_BYTE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign readData     = readData_reg;
  assign readValid    = readValid_reg;
  assign memReadReq   = memRead_reg;
  assign memWriteReq  = memWrite_reg;
  assign memWriteData = memWdata_reg;
  assign memAddr      = cursor_reg;
  assign directMemAllowed = !indirectMode;
  // Layers share this one value; there is no per-layer scroll port.
  // one scroll for whole display
  assign pixelScroll  = scroll_reg;
  assign depthSelect  = depth_reg;

  // The reserved code reports zero bits per pixel, so a display engine that
  // trusts it draws nothing rather than misreading memory.
  // depth decode, reserved gives zero
  always_comb begin
    case (depth_reg)
      lcr_pkg::DEPTH_1BPP: bitsPerPixel = 3'h1;
      lcr_pkg::DEPTH_2BPP: bitsPerPixel = 3'h2;
      lcr_pkg::DEPTH_4BPP: bitsPerPixel = 3'h4;
      default:             bitsPerPixel = 3'h0;
    endcase
  end
endmodule // lcr_regs

// *** test/lcr_regs_chk_sva.sv ***
// Concurrent checks on the ports of the register bank.
`timescale 1ns/1ns
module lcr_regs_chk (
  input wire logic        mclk, rst_n, indirectMode, directSel, directWrite,
  input wire logic        cmdWrite, paramWrite, paramRead, memAccessDone,
  input wire logic [15:0] directAddr, rowPitch, memAddr, glyphAddr,
  input wire logic [7:0]  directWdata, hostData, charCode, readData, memWriteData,
  input wire logic [4:0]  charHeight,
  input wire logic        readValid, memReadReq, memWriteReq, directMemAllowed,
  input wire logic [2:0]  pixelScroll, bitsPerPixel,
  input wire logic [1:0]  depthSelect
);
  // All checks share the controller clock and stand down while reset is low.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // The cursor moves only on a load or a finished access, so scrolling cannot shift it.
  a_cursor_source: assert property (!$stable(memAddr) |->
    $past(paramWrite || memAccessDone || (directSel && directWrite)))
    else $error("cursor moved without a load or access");
  a_step_moves: assert property (memAccessDone && indirectMode && !cmdWrite &&
    !paramWrite && !directSel && rowPitch != 16'h0000 |=> memAddr != $past(memAddr))
    else $error("cursor did not step after an access");
  a_direct_gate: assert property (directMemAllowed == !indirectMode)
    else $error("direct memory gate wrong");
  a_depth_decode: assert property (bitsPerPixel == (depthSelect == 2'h0 ? 3'h1 :
    depthSelect == 2'h1 ? 3'h2 : depthSelect == 2'h2 ? 3'h4 : 3'h0))
    else $error("pixel depth decode wrong");
  a_read_answer: assert property (directSel && !directWrite && !indirectMode |=> readValid)
    else $error("direct read not answered");
  a_read_cause: assert property (readValid |->
    $past(paramRead || (directSel && !directWrite && !indirectMode)))
    else $error("read answer without a read");
  a_read_refused: assert property (indirectMode && directSel && !paramRead |=> !readValid)
    else $error("direct read answered in indirect mode");
  a_mem_write: assert property (memWriteReq |-> $past(paramWrite && indirectMode) &&
    memWriteData == $past(hostData)) else $error("memory write request wrong");
  a_mem_read: assert property (memReadReq |-> $past(paramRead && indirectMode))
    else $error("memory read request without a read");
  a_config_hold: assert property (!$stable({pixelScroll, depthSelect}) |->
    $past(paramWrite || (directSel && directWrite))) else $error("config changed unasked");
endmodule // lcr_regs_chk

bind lcr_regs lcr_regs_chk u_chk (.*);

// *** test/lcr_host.sv ***
// Host processor model driving the register bank's access strobes.
`timescale 1ns/1ns
module lcr_host (
  input  wire logic        mclk,
  input  wire logic [7:0]  readData,
  input  wire logic        readValid,
  output logic             directSel, directWrite, cmdWrite, paramWrite, paramRead,
  output logic             memAccessDone,
  output logic      [15:0] directAddr,
  output logic      [7:0]  directWdata, hostData
);
  // Strobes start idle; the data lines start at a pattern that no test expects.
  initial begin
    {directSel, directWrite, cmdWrite, paramWrite, paramRead, memAccessDone} = 6'h00;
    directAddr = 16'hFFFF;
    directWdata = 8'hC3;
    hostData = 8'hC3;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one strobe per byte
  // Each byte is held for one taking edge, then the bus shows its inverse so stale
  // data can never pass for fresh. Strobe order is {sel, write, cmd, param, read, done}.
  task automatic acc(input logic [5:0] ctl, input logic [15:0] a, input logic [7:0] d,
                     output logic [7:0] r, output logic v);
    @(posedge mclk);
    {directSel, directWrite, cmdWrite, paramWrite, paramRead, memAccessDone} <= ctl;
    directAddr <= a;
    directWdata <= d;
    hostData <= d;
    @(posedge mclk);
    {directSel, directWrite, cmdWrite, paramWrite, paramRead, memAccessDone} <= 6'h00;
    directWdata <= ~d;
    hostData <= ~d;
    #1;
    r = readData;
    v = readValid;
  endtask
endmodule // lcr_host

// *** test/testbench.sv ***
// Self-checking bench for the glyph base, scroll, cursor and depth register bank.
`timescale 1ns/1ns
module testbench;
  logic        mclk, rst_n, indirectMode, directSel, directWrite, cmdWrite, paramWrite;
  logic        paramRead, memAccessDone, readValid, memReadReq, memWriteReq, rv;
  logic        directMemAllowed;
  logic [15:0] directAddr, rowPitch, memAddr, glyphAddr;
  logic [7:0]  directWdata, hostData, charCode, readData, memWriteData, rd;
  logic [4:0]  charHeight;
  logic [2:0]  pixelScroll, bitsPerPixel;
  logic [1:0]  depthSelect;
  int          fails, nTests;
  logic [2:0]  bpp [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
  logic [7:0]  dirCmd [4] = '{8'h4C, 8'h4F, 8'h4E, 8'h4D};
  logic [15:0] dirExp [4] = '{16'h1235, 16'h125D, 16'h1235, 16'h1234};
  logic [15:0] resetOffs [5] = '{16'h8019, 16'h801A, 16'h801E, 16'h801F, 16'h8020};

  lcr_regs dut (.*);
  lcr_host host (.*);
  ////////////////////////////////////////////////////////////////////////////////
  // Free-running 50 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Cut a hang short; the whole sequence needs about 120 cycles.
  initial begin
    repeat (3000) @(posedge mclk);
    fails++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Compare, count and report.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nTests++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic dwr(input logic [15:0] a, input logic [7:0] d);
    host.acc(6'h30, a, d, rd, rv);
  endtask
  task automatic drd(input logic [15:0] a, input logic [7:0] e);
    host.acc(6'h20, a, 8'h00, rd, rv);
    chk({7'h00, rv, rd}, {8'h01, e});
  endtask
  task automatic cmd(input logic [7:0] c);
    host.acc(6'h08, 16'h0000, c, rd, rv);
  endtask
  task automatic par(input logic [7:0] d);
    host.acc(6'h04, 16'h0000, d, rd, rv);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: direct access first, then the indirect command set.
  initial begin
    {indirectMode, rst_n} = 2'h0;
    rowPitch = 16'h0028;
    charCode = 8'h80;
    charHeight = 5'h08;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (resetOffs[i]) drd(resetOffs[i], 8'h00);
    dwr(lcr_pkg::OFF_GLYPH_LO, 8'h00);
    dwr(lcr_pkg::OFF_GLYPH_HI, 8'h60);
    drd(lcr_pkg::OFF_GLYPH_HI, 8'h60);
    chk(glyphAddr, 16'h6400);
    dwr(lcr_pkg::OFF_CURRD_LO, 8'h5A);
    drd(lcr_pkg::OFF_CURRD_LO, 8'h00);
    drd(16'h8021, 8'h00);
    dwr(lcr_pkg::OFF_CURSOR_LO, 8'h78);
    dwr(lcr_pkg::OFF_CURSOR_HI, 8'h56);
    chk(memAddr, 16'h5678);
    drd(lcr_pkg::OFF_CURRD_HI, 8'h56);
    for (int i = 0; i < 4; i++) begin
      dwr(lcr_pkg::OFF_DEPTH, 8'(i));
      chk({11'h000, depthSelect, bitsPerPixel}, {11'h000, 2'(i), bpp[i]});
    end
    dwr(lcr_pkg::OFF_DEPTH, 8'h00);
    chk({13'h0000, bitsPerPixel}, 16'h0001);
    dwr(lcr_pkg::OFF_SCROLL, 8'hFB);
    drd(lcr_pkg::OFF_SCROLL, 8'h03);
    dwr(lcr_pkg::OFF_SCROLL, 8'h00);
    $display("direct access test done");
    @(posedge mclk);
    indirectMode <= 1'b1;
    dwr(lcr_pkg::OFF_GLYPH_LO, 8'hFF);
    chk({glyphAddr[15:1], directMemAllowed}, 16'h6400);
    cmd(lcr_pkg::CMD_GLYPH_BASE);
    par(8'h34);
    chk(glyphAddr, 16'h6434);
    par(8'h12);
    chk(glyphAddr, 16'h1634);
    // Depth steps down to 1 bpp last, so scrolling below runs at a legal depth.
    for (int i = 3; i >= 0; i--) begin
      cmd(lcr_pkg::CMD_DEPTH);
      par(8'(i));
      chk({14'h0000, depthSelect}, 16'(i));
    end
    cmd(lcr_pkg::CMD_CURSOR_WR);
    par(8'h34);
    chk(memAddr, 16'h5634);
    par(8'h12);
    chk(memAddr, 16'h1234);
    // scroll only at one bit per pixel
    cmd(lcr_pkg::CMD_SCROLL);
    par(8'h05);
    chk({pixelScroll, memAddr[12:0]}, {3'h5, 13'h1234});
    cmd(lcr_pkg::CMD_CURSOR_RD);
    host.acc(6'h02, 16'h0000, 8'h00, rd, rv);
    chk({rv, rd}, 16'h0134);
    host.acc(6'h02, 16'h0000, 8'h00, rd, rv);
    chk({rv, rd}, 16'h0112);
    host.acc(6'h02, 16'h0000, 8'h00, rd, rv);
    chk({15'h0000, rv}, 16'h0000);
    cmd(lcr_pkg::CMD_MEM_WRITE);
    par(8'hAB);
    chk({memWriteReq, memWriteData, memAddr[6:0]}, {1'b1, 8'hAB, 7'h34});
    for (int i = 0; i < 4; i++) begin
      if (i > 0) cmd(dirCmd[i]);
      host.acc(6'h01, 16'h0000, 8'h00, rd, rv);
      chk(memAddr, dirExp[i]);
    end
    cmd(lcr_pkg::CMD_MEM_READ);
    host.acc(6'h02, 16'h0000, 8'h00, rd, rv);
    chk({15'h0000, memReadReq}, 16'h0001);
    $display("indirect command test done");
    // A reset in mid-run must return every stored byte and output to its reset value.
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    chk(glyphAddr, 16'h0400);
    chk({8'h00, pixelScroll, depthSelect, bitsPerPixel}, 16'h0001);
    chk(memAddr, 16'h0000);
    chk({7'h00, readValid, readData}, 16'h0000);
    $display("reset test done");
    summarize();
  end
endmodule // testbench
